// >>> verilog/lrc_flow_ctrl.sv
/*
  Loop counting, conditional returns, stack use and single-vector interrupt
  entry and exit for a 16-bit accumulator core.
  Assumes one decoded instruction is offered per boundary on i_op_valid and
  that peripheral flags and local enables are synchronous to i_clk.
*/
`timescale 1ns/1ns
module lrc_flow_ctrl #(
  parameter int unsigned N_IRQ       = 16,
  parameter int unsigned STACK_DEPTH = 16
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_sys_rst,
  input  wire logic                           i_op_valid,
  output logic                                o_op_ready,
  input  wire lrc_pkg::lrc_op_t               i_op,
  input  wire lrc_pkg::lrc_cond_t             i_cond,
  input  wire logic                           i_lc_sel,
  input  wire logic                           i_src_wide,
  input  wire logic                           i_src_rel,
  input  wire logic [15:0]                    i_src,
  input  wire logic [15:0]                    i_acc,
  input  wire logic                           i_carry,
  input  wire logic                           i_global_irq_enable,
  input  wire logic [N_IRQ-1:0]               i_irq_mask,
  input  wire logic [N_IRQ-1:0]               i_irq_local_en,
  input  wire logic [N_IRQ-1:0]               i_irq_flag,
  output logic      [15:0]                    o_instruction_pointer,
  output logic      [15:0]                    o_loop_count_0,
  output logic      [15:0]                    o_loop_count_1,
  output logic      [15:0]                    o_interrupt_vector,
  output logic      [7:0]                     o_high_byte_prefix,
  output logic                                o_in_service,
  output logic      [N_IRQ-1:0]               o_irq_id,
  output logic                                o_irq_taken,
  output logic                                o_branch_taken,
  output logic      [$clog2(STACK_DEPTH)-1:0] o_stack_pointer,
  output logic      [15:0]                    o_pop_data,
  output logic                                o_pop_valid
);
  import lrc_pkg::*;

  if (N_IRQ < 1 || N_IRQ > WORD_W) begin : g_chk
    $error("lrc_flow_ctrl: N_IRQ must be 1 to 16");
  end

  logic [15:0]      ip_r;
  logic [15:0]      ip_nxt;
  logic [15:0]      lc0_r;
  logic [15:0]      lc1_r;
  logic [15:0]      iv_r;
  logic [7:0]       pfx_r;
  logic             ins_r;
  logic [N_IRQ-1:0] id_r;
  logic             taken_r;
  logic             branch_r;
  logic [15:0]      pop_data_r;
  logic             pop_valid_r;

  logic             zero_flag;
  logic             sign_flag;
  logic             irq_req;
  logic             take;
  logic             exec;
  logic             cond_ok;
  logic [15:0]      lc_sel_val;
  logic [15:0]      lc_dec;
  logic             loop_go;
  logic [15:0]      src_val;
  logic [15:0]      target;
  logic             ret_go;
  logic             push_en;
  logic             pop_en;
  logic [15:0]      push_data;
  logic [15:0]      stack_top;
  logic [N_IRQ-1:0] id_nxt;

  function automatic logic cond_true(lrc_cond_t c, logic cy, logic z, logic s);
    unique case (c)
      CND_ALWAYS: cond_true = 1'b1;
      CND_C:      cond_true = cy; // RULE5
      CND_NC:     cond_true = !cy; // RULE5
      CND_Z:      cond_true = z; // RULE5
      CND_NZ:     cond_true = !z; // RULE5
      CND_S:      cond_true = s; // RULE5
      default:    cond_true = 1'b0;
    endcase
  endfunction

  // Narrow operands borrow the prefix as their high byte
  function automatic logic [15:0] operand(logic wide, logic [15:0] s, logic [7:0] p);
    operand = wide ? s : {p, s[7:0]}; // RULE16 RULE3
  endfunction

  assign zero_flag = (i_acc == 16'h0000); // RULE19
  assign sign_flag = i_acc[WORD_W-1]; // RULE19

  for (genvar g = 0; g < N_IRQ; g++) begin : g_id
    assign id_nxt[g] = i_irq_flag[g] & i_irq_local_en[g]; // RULE9 RULE12
  end

  assign irq_req = i_global_irq_enable && !ins_r && |(id_r & i_irq_mask); // RULE7 RULE8
  assign take    = i_op_valid && irq_req; // RULE20
  assign exec    = i_op_valid && !irq_req;
  assign o_op_ready = !irq_req;

  assign cond_ok    = cond_true(i_cond, i_carry, zero_flag, sign_flag);
  assign lc_sel_val = i_lc_sel ? lc1_r : lc0_r; // RULE2
  assign lc_dec     = lc_sel_val - ONE_WORD; // RULE1
  assign loop_go    = exec && i_op == OP_DJNZ && lc_dec != 16'h0000; // RULE1
  assign src_val    = operand(i_src_wide, i_src, pfx_r);
  // Relative targets count from the address after the instruction
  assign target = i_src_rel ? ip_r + ONE_WORD + {{8{i_src[7]}}, i_src[7:0]} // RULE3
                            : src_val;
  assign ret_go = exec && (i_op == OP_RET || i_op == OP_RETI) && cond_ok; // RULE4 RULE13

  assign push_en = take || (exec && (i_op == OP_CALL || i_op == OP_PUSH)); // RULE14
  assign pop_en  = ret_go || (exec && (i_op == OP_POP || i_op == OP_POPI)); // RULE18

  always_comb begin
    push_data = src_val; // RULE16
    if (take) begin
      push_data = ip_r;
    end else if (i_op == OP_CALL) begin
      push_data = ip_r + ONE_WORD; // RULE17
    end
  end

  always_comb begin
    ip_nxt = ip_r;
    if (take) begin
      ip_nxt = iv_r; // RULE6 RULE8
    end else if (exec) begin
      ip_nxt = ip_r + ONE_WORD; // RULE1 RULE4
      if (loop_go || i_op == OP_CALL) begin
        ip_nxt = target; // RULE1 RULE17
      end else if (ret_go) begin
        ip_nxt = stack_top; // RULE4 RULE11
      end
    end
  end

  lrc_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_push    (push_en),
    .i_pop     (pop_en),
    .i_wdata   (push_data),
    .o_top     (stack_top),
    .o_sp      (o_stack_pointer)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ip_r <= IP_RESET;
    end else begin
      ip_r <= ip_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lc0_r <= LC_RESET;
      lc1_r <= LC_RESET;
    end else if (exec && i_op == OP_DJNZ) begin
      if (i_lc_sel) begin
        lc1_r <= lc_dec; // RULE1 RULE2
      end else begin
        lc0_r <= lc_dec; // RULE1 RULE2
      end
    end else if (exec && i_op == OP_LC_WR) begin
      if (i_lc_sel) begin
        lc1_r <= src_val;
      end else begin
        lc0_r <= src_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      iv_r <= IV_RESET; // RULE6
    end else if (exec && i_op == OP_IV_WR) begin
      iv_r <= src_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pfx_r <= PFX_RESET;
    end else if (exec && i_op == OP_PFX_WR) begin
      pfx_r <= i_src[7:0];
    end
  end

  // Entry and exit never meet: a taken interrupt holds off the instruction
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ins_r <= 1'b0;
    end else if (take) begin
      ins_r <= 1'b1; // RULE8
    end else if (ret_go && i_op == OP_RETI) begin
      ins_r <= 1'b0; // RULE11 RULE13
    end else if (exec && (i_op == OP_POPI || i_op == OP_INS_CLR)) begin
      ins_r <= 1'b0; // RULE18
    end
  end

  // Read-only view of module flags; only the modules can clear them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      id_r <= '0;
    end else begin
      id_r <= id_nxt; // RULE10 RULE12
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      taken_r  <= 1'b0;
      branch_r <= 1'b0;
    end else begin
      taken_r  <= take;
      branch_r <= loop_go || ret_go || (exec && i_op == OP_CALL);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pop_data_r  <= 16'h0000;
      pop_valid_r <= 1'b0;
    end else begin
      pop_valid_r <= exec && (i_op == OP_POP || i_op == OP_POPI);
      if (exec && (i_op == OP_POP || i_op == OP_POPI)) begin
        pop_data_r <= stack_top; // RULE18
      end
    end
  end

  assign o_instruction_pointer = ip_r;
  assign o_loop_count_0        = lc0_r;
  assign o_loop_count_1        = lc1_r;
  assign o_interrupt_vector    = iv_r;
  assign o_high_byte_prefix    = pfx_r;
  assign o_in_service          = ins_r;
  assign o_irq_id              = id_r;
  assign o_irq_taken           = taken_r;
  assign o_branch_taken        = branch_r;
  assign o_pop_data            = pop_data_r;
  assign o_pop_valid           = pop_valid_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_loop_branch: assert property (loop_go |=> ip_r == $past(target)) // RULE1
    else $error("loop did not branch to target");
  a_loop_fall: assert property (exec && i_op == OP_DJNZ && lc_dec == 16'h0000
    |=> ip_r == $past(ip_r) + ONE_WORD) // RULE1
    else $error("loop did not fall through at zero");
  a_lc_indep: assert property (exec && i_op == OP_DJNZ && i_lc_sel
    |=> lc0_r == $past(lc0_r) && lc1_r == $past(lc1_r) - ONE_WORD) // RULE2
    else $error("loop counters not independent");
  a_far_target: assert property (exec && i_op == OP_CALL && !i_src_rel && !i_src_wide
    |=> ip_r == {$past(pfx_r), $past(i_src[7:0])}) // RULE3
    else $error("far target not built from prefix");
  a_ret_hold: assert property (exec && i_op inside {OP_RET, OP_RETI} && !cond_ok
    |=> ip_r == $past(ip_r) + ONE_WORD && $stable(o_stack_pointer)
        && $stable(ins_r)) // RULE4
    else $error("failed return changed state");
  a_ret_pop: assert property (ret_go |=> ip_r == $past(stack_top)
    && o_stack_pointer == $past(o_stack_pointer) - 1'b1) // RULE13
    else $error("return did not pop");
  a_irq_entry: assert property (take |=> ip_r == $past(iv_r) && ins_r && o_irq_taken) // RULE8
    else $error("interrupt entry wrong");
  a_irq_gate: assert property (take |-> i_global_irq_enable && !ins_r
    && |(id_r & i_irq_mask & $past(i_irq_local_en))) // RULE7
    else $error("interrupt taken without enables");
  a_ins_blocks: assert property (ins_r |-> !take) // RULE8
    else $error("interrupt taken while in service");
  a_reti_clear: assert property (ret_go && i_op == OP_RETI |=> !ins_r) // RULE11
    else $error("interrupt return left in-service set");
  a_id_follows: assert property (##1 id_r == $past(i_irq_flag & i_irq_local_en)) // RULE12
    else $error("identification bits do not follow flags");
  a_push_prefix: assert property (exec && i_op == OP_PUSH && !i_src_wide
    |=> stack_top == {$past(pfx_r), $past(i_src[7:0])}) // RULE16
    else $error("narrow push missed prefix");
  a_call_link: assert property (exec && i_op == OP_CALL
    |=> stack_top == $past(ip_r) + ONE_WORD) // RULE17
    else $error("call pushed wrong address");

  c_loop_back: cover property (loop_go ##1 loop_go);
  c_irq_taken: cover property (take ##[1:20] ret_go && i_op == OP_RETI);
  c_masked_id: cover property (|(id_r & ~i_irq_mask) && !irq_req);
  c_cond_fail: cover property (exec && i_op == OP_RET && !cond_ok);
endmodule

// >>> pkg/lrc_pkg.sv
/*
  Shared constants and types for the loop, return and interrupt control block.
  Assumes a single core clock and a synchronous active-high reset.
*/
// What this block does
// RULE1 - Loop instruction decrements chosen counter, branches if not zero, else falls through.
// RULE2 - Two independent 16-bit loop counters, either selectable by the loop instruction.
// RULE3 - Near loop target is relative offset; far target is prefix high byte plus operand.
// RULE4 - Conditional return pops and resumes when true; otherwise stack unchanged and IP steps to next instruction.
// RULE5 - Return conditions: carry set, carry clear, zero set, zero clear, sign set.
// RULE6 - 16-bit interrupt vector resets to zero; every interrupt branches to it.
// RULE7 - Interrupt accepted only with global enable, module mask and local enable set.
// RULE8 - Accepting an interrupt sets in-service, blocking others, and jumps to vector.
// RULE9 - One shared vector; identification bit n shows pending interrupt of module n.
// RULE10 - Identification bits cannot be written; they clear with the module's own flag.
// RULE11 - Return-from-interrupt pops return address and clears in-service automatically.
// RULE12 - Mask bit zero blocks only the request; identification bit still gets set.
// RULE13 - Conditional interrupt return pops, clears in-service when true; else only IP steps to next instruction.
// RULE14 - Stack entries are 16 bits; used by call, returns and explicit data pushes.
// RULE15 - Push increments stack pointer first, then writes the new top entry.
// RULE16 - Pushing 8-bit source stores prefix as high byte; 16-bit source stored whole.
// RULE17 - Call pushes next instruction address before jumping to the target.
// RULE18 - Pop reads top then decrements pointer; interrupt pop also clears in-service.
// RULE19 - Zero flag is one when accumulator is all zero; sign is its top bit.
// RULE20 - Interrupts are taken only at an instruction boundary.
package lrc_pkg;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam logic [15:0] LC_RESET  = 16'h0000;
  localparam logic [15:0] IV_RESET  = 16'h0000;
  localparam logic [15:0] IP_RESET  = 16'h0000;
  localparam logic [7:0]  PFX_RESET = 8'h00;
  localparam logic [15:0] ONE_WORD  = 16'h0001;

  typedef enum logic [3:0] {
    OP_NEXT    = 4'h0,
    OP_DJNZ    = 4'h1,
    OP_CALL    = 4'h2,
    OP_RET     = 4'h3,
    OP_RETI    = 4'h4,
    OP_PUSH    = 4'h5,
    OP_POP     = 4'h6,
    OP_POPI    = 4'h7,
    OP_LC_WR   = 4'h8,
    OP_IV_WR   = 4'h9,
    OP_PFX_WR  = 4'hA,
    OP_INS_CLR = 4'hB
  } lrc_op_t;

  typedef enum logic [2:0] {
    CND_ALWAYS = 3'h0,
    CND_C      = 3'h1,
    CND_NC     = 3'h2,
    CND_Z      = 3'h3,
    CND_NZ     = 3'h4,
    CND_S      = 3'h5
  } lrc_cond_t;
endpackage

// >>> verilog/lrc_stack.sv
/*
  Hardware stack of 16-bit words in flip-flops.
  Assumes the caller never pushes and pops in the same cycle.
*/
`timescale 1ns/1ns
module lrc_stack #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_push,
  input  wire logic                     i_pop,
  input  wire logic [15:0]              i_wdata,
  output logic      [15:0]              o_top,
  output logic      [$clog2(DEPTH)-1:0] o_sp
);
  import lrc_pkg::*;
  localparam int unsigned SPW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << SPW) != DEPTH) begin : g_chk
    $error("lrc_stack: DEPTH must be a power of two of at least 2");
  end

  logic [15:0]    mem_r [DEPTH];
  logic [SPW-1:0] sp_r;
  logic [SPW-1:0] sp_inc;

  assign sp_inc = sp_r + SPW'(1);
  assign o_top  = mem_r[sp_r];
  assign o_sp   = sp_r;

  // Reset leaves the pointer all ones so the first push lands at entry 0
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_r <= '1;
    end else if (i_push) begin
      sp_r <= sp_inc; // RULE15
    end else if (i_pop) begin
      sp_r <= sp_r - SPW'(1); // RULE18
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_r[sp_inc] <= i_wdata; // RULE15 RULE14
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_push_writes_top: assert property (i_push |=> o_top == $past(i_wdata)) // RULE15
    else $error("push did not land at new top");
  a_pop_moves_down: assert property (i_pop && !i_push |=> o_sp == $past(o_sp) - SPW'(1)) // RULE18
    else $error("pop did not decrement pointer");
endmodule

// >>> dv/lrc_irq_src.sv
/*
  Model of the peripheral modules that raise interrupt requests.
  Assumes set and clear strobes come from the bench, synchronous to i_clk.
*/
`timescale 1ns/1ns
module lrc_irq_src #(
  parameter int unsigned N = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [N-1:0] i_set,
  input  wire logic [N-1:0] i_clr,
  input  wire logic [N-1:0] i_en,
  output logic      [N-1:0] o_flag,
  output logic      [N-1:0] o_local_en
);
  // A flag drops only through its own module's clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flag <= '0;
    end else begin
      o_flag <= (o_flag & ~i_clr) | i_set;
    end
  end

  assign o_local_en = i_en;
endmodule

// >>> dv/loop_return_interrupt_control_test.sv
/*
  Self-checking bench for loops, stack use, conditional returns and
  interrupt entry and exit.
  Assumes lrc_pkg and the peripheral flag model are compiled first.
*/
`timescale 1ns/1ns
module loop_return_interrupt_control_test;
  import lrc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_op_valid = 1'b0;
  lrc_op_t     i_op = OP_NEXT;
  lrc_cond_t   i_cond = CND_ALWAYS;
  logic        i_lc_sel = 1'b0;
  logic        i_src_wide = 1'b1;
  logic        i_src_rel = 1'b0;
  logic [15:0] i_src = 16'h0000;
  logic [15:0] i_acc = 16'h0000;
  logic        i_carry = 1'b0;
  logic        i_ige = 1'b0;
  logic [15:0] i_mask = 16'h0000;
  logic [15:0] irq_set = 16'h0000;
  logic [15:0] irq_clr = 16'h0000;
  logic [15:0] irq_en = 16'h0000;
  logic [15:0] irq_flag, irq_len, ip, lc0, lc1, iv, id, pd, ip_e, ret_a;
  logic [7:0]  pfx;
  logic [3:0]  sp;
  logic        rdy_w, in_service_flag, taken, br, pv, rdy;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  lrc_irq_src #(.N(16)) PEER (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_set(irq_set), .i_clr(irq_clr),
    .i_en(irq_en), .o_flag(irq_flag), .o_local_en(irq_len));

  lrc_flow_ctrl #(.N_IRQ(16), .STACK_DEPTH(16)) DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid),
    .o_op_ready(rdy_w), .i_op(i_op), .i_cond(i_cond), .i_lc_sel(i_lc_sel),
    .i_src_wide(i_src_wide), .i_src_rel(i_src_rel), .i_src(i_src),
    .i_acc(i_acc), .i_carry(i_carry), .i_global_irq_enable(i_ige),
    .i_irq_mask(i_mask), .i_irq_local_en(irq_len), .i_irq_flag(irq_flag),
    .o_instruction_pointer(ip), .o_loop_count_0(lc0), .o_loop_count_1(lc1),
    .o_interrupt_vector(iv), .o_high_byte_prefix(pfx), .o_in_service(in_service_flag),
    .o_irq_id(id), .o_irq_taken(taken), .o_branch_taken(br),
    .o_stack_pointer(sp), .o_pop_data(pd), .o_pop_valid(pv));

  always #50 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offers one instruction at the next edge; ready is noted before that edge
  // Valid stays up afterwards so back-to-back ops never toggle it in one step
  task op(input lrc_op_t o, input logic [15:0] v = 16'h0000, input logic s = 1'b0,
          input logic w = 1'b1, input logic r = 1'b0, input lrc_cond_t c = CND_ALWAYS);
    i_op = o;
    i_src = v;
    i_lc_sel = s;
    i_src_wide = w;
    i_src_rel = r;
    i_cond = c;
    i_op_valid = 1'b1;
    #1 rdy = rdy_w;
    @(posedge i_clk);
    #1;
    if (rdy) begin
      ip_e = ip_e + 16'h0001;
    end
  endtask

  task t_reset;
    repeat (2) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    ip_e = 16'h0000;
    chk("vector", 16'h0000, iv);
    chk("count0", 16'h0000, lc0);
    chk("count1", 16'h0000, lc1);
    chk("in_service", 16'h0000, in_service_flag);
    chk("sp", 16'h000F, sp);
  endtask

  task t_loop;
    op(OP_LC_WR, 16'h0002, 1'b1);
    chk("count1", 16'h0002, lc1);
    op(OP_DJNZ, 16'h00FE, 1'b1, 1'b1, 1'b1);
    ip_e = 16'h0000;
    chk("ip", ip_e, ip);
    chk("count1", 16'h0001, lc1);
    chk("branch", 16'h0001, br);
    op(OP_DJNZ, 16'h00FE, 1'b1, 1'b1, 1'b1);
    chk("ip", ip_e, ip);
    chk("branch", 16'h0000, br);
    chk("count0", 16'h0000, lc0);
    op(OP_PFX_WR, 16'h0012);
    chk("prefix", 16'h0012, pfx);
    op(OP_LC_WR, 16'h0034, 1'b0, 1'b0);
    chk("count0", 16'h1234, lc0);
    op(OP_DJNZ, 16'h0056, 1'b0, 1'b0);
    ip_e = 16'h1256;
    chk("ip", ip_e, ip);
    chk("count0", 16'h1233, lc0);
  endtask

  task t_stack;
    op(OP_PFX_WR, 16'h009A);
    op(OP_PUSH, 16'h00BC, 1'b0, 1'b0);
    chk("sp", 16'h0000, sp);
    op(OP_PUSH, 16'h1357);
    chk("sp", 16'h0001, sp);
    op(OP_POP);
    chk("pop", 16'h1357, pd);
    chk("pop_valid", 16'h0001, pv);
    op(OP_POP);
    chk("pop", 16'h9ABC, pd);
    chk("sp", 16'h000F, sp);
  endtask

  task t_ret;
    lrc_cond_t   cl [5] = '{CND_C, CND_NC, CND_Z, CND_NZ, CND_S};
    logic [16:0] fv [5] = '{17'h00001, 17'h10001, 17'h00001, 17'h00000, 17'h07FFF};
    logic [16:0] tv [5] = '{17'h10001, 17'h00001, 17'h00000, 17'h00001, 17'h08000};
    for (int k = 0; k < 5; k++) begin
      {i_carry, i_acc} = fv[k];
      ret_a = ip_e + 16'h0001;
      op(OP_CALL, 16'h0400 + 16'(k));
      ip_e = 16'h0400 + 16'(k);
      chk("ip", ip_e, ip);
      op(OP_RET, 16'h0000, 1'b0, 1'b1, 1'b0, cl[k]);
      chk("ip", ip_e, ip);
      chk("sp", 16'h0000, sp);
      {i_carry, i_acc} = tv[k];
      op(OP_RET, 16'h0000, 1'b0, 1'b1, 1'b0, cl[k]);
      ip_e = ret_a;
      chk("ip", ip_e, ip);
      chk("sp", 16'h000F, sp);
    end
    ret_a = ip_e + 16'h0001;
    op(OP_CALL, 16'h0500);
    chk("sp", 16'h0000, sp);
    op(OP_RET);
    ip_e = ret_a;
    chk("ip", ip_e, ip);
  endtask

  task t_irq;
    op(OP_IV_WR, 16'h0200);
    chk("vector", 16'h0200, iv);
    i_ige = 1'b1;
    irq_en = 16'h0028;
    irq_set = 16'h0008;
    op(OP_NEXT);
    irq_set = 16'h0000;
    op(OP_NEXT);
    chk("id", 16'h0008, id);
    op(OP_NEXT);
    chk("ready", 16'h0001, rdy);
    i_mask = 16'h0028;
    i_op_valid = 1'b0;
    @(posedge i_clk);
    #1 chk("in_service", 16'h0000, in_service_flag);
    ret_a = ip_e;
    op(OP_NEXT);
    chk("ready", 16'h0000, rdy);
    ip_e = 16'h0200;
    chk("ip", ip_e, ip);
    chk("in_service", 16'h0001, in_service_flag);
    chk("taken", 16'h0001, taken);
    chk("sp", 16'h0000, sp);
    irq_clr = 16'h0008;
    irq_set = 16'h0020;
    op(OP_NEXT);
    chk("taken", 16'h0000, taken);
    irq_clr = 16'h0000;
    irq_set = 16'h0000;
    op(OP_NEXT);
    op(OP_NEXT);
    chk("ready", 16'h0001, rdy);
    chk("id", 16'h0020, id);
    op(OP_RETI, 16'h0000, 1'b0, 1'b1, 1'b0, CND_C);
    chk("in_service", 16'h0001, in_service_flag);
    chk("sp", 16'h0000, sp);
    op(OP_RETI, 16'h0000, 1'b0, 1'b1, 1'b0, CND_NC);
    ip_e = ret_a;
    chk("ip", ip_e, ip);
    chk("in_service", 16'h0000, in_service_flag);
    chk("sp", 16'h000F, sp);
    i_mask = 16'h0008;
    op(OP_NEXT);
    chk("ready", 16'h0001, rdy);
    chk("id", 16'h0020, id);
    i_mask = 16'h0020;
    ret_a = ip_e;
    op(OP_NEXT);
    chk("ready", 16'h0000, rdy);
    chk("in_service", 16'h0001, in_service_flag);
    i_mask = 16'h0000;
    op(OP_POPI);
    chk("pop", ret_a, pd);
    chk("in_service", 16'h0000, in_service_flag);
    chk("sp", 16'h000F, sp);
    i_mask = 16'h0020;
    op(OP_NEXT);
    chk("taken", 16'h0001, taken);
    i_mask = 16'h0000;
    op(OP_INS_CLR);
    chk("in_service", 16'h0000, in_service_flag);
  endtask

  initial begin
    t_reset;
    t_loop;
    t_stack;
    t_ret;
    t_irq;
    end_sim;
  end
endmodule
